// File: src/mmc_map.vh
// Memory map control constants: register indices, fields, reset values, map windows.
// Assumes inclusion by the mode control design files only.
`ifndef MMC_MAP_VH
`define MMC_MAP_VH
// Register indices; byte address on APB is four times the index
`define IDX_RSVD_0A      8'h0a
`define IDX_MODE         8'h0b
`define IDX_RSVD_10      8'h10
`define IDX_DIRECT       8'h11
`define IDX_RSVD_12      8'h12
`define IDX_RSVD_13      8'h13
`define IDX_RSVD_14      8'h14
`define IDX_PAGE         8'h15
// Own choice: read-only status register index
`define IDX_STATUS       8'h16
// Fields
`define MODE_BIT         7
`define PAGE_MSB         3
// Reset values
`define DIRECT_RST       8'h00
`define PAGE_RST         4'he
// Local windows and mode encodings
`define WIN_LO           2'b10
`define FIX_PAGE_0       4'hc
`define FIX_PAGE_1       4'hd
`define FIX_PAGE_3       4'hf
`define DBG_RES_HI       8'hff
`define MODE_SS          1'b0
`define MODE_NS          1'b1
`endif

// File: src/mmc_regs.v
// Register store for the memory map control block: direct page and flash page.
// Assumes writes arrive as single-cycle strobes on the system clock.
`timescale 1ns/1ps
`include "mmc_map.vh"
module mmc_regs (
  input  wire       ref_clk_i,    // System clock
  input  wire       rst_n_i,      // Async reset, active low
  input  wire       dir_we_i,     // Direct page write strobe
  input  wire       page_we_i,    // Flash page write strobe
  input  wire [7:0] wdata_i,      // Write data
  output reg  [7:0] direct_o,     // Direct page base
  output reg  [3:0] page_o        // Flash page index
);
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      direct_o <= `DIRECT_RST;
      page_o   <= `PAGE_RST;
    end else begin
      if (dir_we_i) begin
        direct_o <= wdata_i;
      end
      if (page_we_i) begin
        page_o <= wdata_i[`PAGE_MSB:0];
      end
    end
  end
endmodule

// File: src/mmc_top.v
// Memory map and mode control: two-master arbitration, paging, mode and security.
// Assumes an APB master on the system clock and single-cycle master requests.
//
// Functional notes
// - Mode pin captured on the third edge after reset release
// - Only normal and special single-chip modes
// - Special mode enters debug after reset
// - Unmapped core access triggers system reset
// - Paging reaches 256 kByte global space
// - Arbitrate core and debug master accesses
// - Separate address decode per master
// - Secured part blocks external flash access
// - Even address aligned, odd misaligned
// - Page index maps flash at 0x8000-0xBFFF
// - Direct page forms local address bits 15:8
// - Illegal mode write ignored, locks in normal
// - Mode register writes ignored while secured
`timescale 1ns/1ps
`include "mmc_map.vh"
module mmc_top #(
  parameter MAP_TOP = 16'hbfff   // Highest implemented core address below fixed pages
) (
  input  wire        ref_clk_i,      // 100 MHz system clock
  input  wire        rst_n_i,        // Async reset, active low
  input  wire        mode_select_pin_i, // Mode strap pin, async
  input  wire        secured_i,      // Part secured, from flash logic
  input  wire        cpu_req_i,      // Core access request
  input  wire [15:0] cpu_addr_i,     // Core local address
  input  wire        cpu_direct_i,   // Core access uses direct addressing
  input  wire        dbg_req_i,      // Debug module access request
  input  wire [15:0] dbg_addr_i,     // Debug module local address
  input  wire        dbg_ext_i,      // Debug access comes from outside
  input  wire        dbg_active_i,   // Debug firmware is active
  input  wire        psel,           // APB select
  input  wire        penable,        // APB enable
  input  wire        pwrite,         // APB direction
  input  wire [31:0] paddr,          // APB byte address
  input  wire [31:0] pwdata,         // APB write data
  output wire        pready,         // APB ready
  output reg  [31:0] prdata,         // APB read data
  output wire        pslverr,        // APB error
  output wire        cpu_gnt_o,      // Core granted this cycle
  output wire        dbg_gnt_o,      // Debug module granted this cycle
  output reg  [17:0] glb_addr_o,     // Global address of granted access
  output reg         glb_valid_o,    // Global address valid
  output reg         misaligned_o,   // Granted access is odd
  output reg         flash_blk_o,    // Access refused by security
  output reg         sys_reset_req_o, // System reset on illegal access
  output wire        special_mode_o, // Special single-chip mode
  output reg         debug_entry_o   // Enter active debug after reset
);
  localparam ST_IDLE = 3'b001;
  localparam ST_CPU  = 3'b010;
  localparam ST_DBG  = 3'b100;

  reg        pin_s1;
  reg        pin_s2;
  reg        strap_done;
  reg  [1:0] strap_wait;
  reg        mode_bit;
  reg        mode_lock;
  reg  [2:0] state;
  reg  [2:0] next_state;
  reg        last_dbg;
  wire [7:0] direct;
  wire [3:0] page;
  wire [7:0] idx;
  wire       wr;
  wire       mode_wr;
  wire       mode_ok;

  assign idx     = paddr[9:2];
  assign wr      = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign special_mode_o = (mode_bit == `MODE_SS);

  // Strap passes two flops; first flop read only by the second
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end else begin
      pin_s1 <= mode_select_pin_i;
      pin_s2 <= pin_s1;
    end
  end

  // Any write in special mode, or a write keeping normal in normal mode, is permitted
  assign mode_ok = (mode_bit == `MODE_SS) | (pwdata[`MODE_BIT] == mode_bit);
  assign mode_wr = wr & (idx == `IDX_MODE) & ~secured_i & ~mode_lock;

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_done    <= 1'b0;
      strap_wait    <= 2'b00;
      mode_bit      <= `MODE_NS;
      mode_lock     <= 1'b0;
      debug_entry_o <= 1'b0;
    end else if (!strap_done) begin
      // Wait until both sync flops hold the pin, not their reset value
      strap_wait <= {strap_wait[0], 1'b1};
      if (strap_wait[1]) begin
        strap_done    <= 1'b1;
        mode_bit      <= pin_s2;
        debug_entry_o <= (pin_s2 == `MODE_SS);
      end
    end else begin
      debug_entry_o <= 1'b0;
      if (mode_wr) begin
        if (mode_ok) begin
          mode_bit <= pwdata[`MODE_BIT];
        end else if (mode_bit == `MODE_NS) begin
          mode_lock <= 1'b1;
        end
      end
    end
  end

  // Direct page: any time in special; in normal only while never written since reset
  reg dir_written;
  wire dir_we;
  wire page_we;
  assign dir_we  = wr & (idx == `IDX_DIRECT) & (special_mode_o | ~dir_written);
  assign page_we = wr & (idx == `IDX_PAGE);

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dir_written <= 1'b0;
    end else if (dir_we) begin
      dir_written <= 1'b1;
    end
  end

  mmc_regs u_regs (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .dir_we_i  (dir_we),
    .page_we_i (page_we),
    .wdata_i   (pwdata[7:0]),
    .direct_o  (direct),
    .page_o    (page)
  );

  // Reserved and unknown indices read zero and ignore writes
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata <= 32'h0;
    end else if (psel & ~penable & ~pwrite) begin
      case (idx)
        `IDX_MODE:   prdata <= {24'h0, mode_bit, 7'h0};
        `IDX_DIRECT: prdata <= {24'h0, direct};
        `IDX_PAGE:   prdata <= {28'h0, page};
        `IDX_STATUS: prdata <= {28'h0, mode_lock, secured_i, dir_written, mode_bit};
        default:     prdata <= 32'h0;
      endcase
    end
  end

  // Local to global translation
  function [17:0] to_global;
    input [15:0] a;
    input [3:0]  pg;
    begin
      case (a[15:14])
        2'b00:   to_global = {`FIX_PAGE_0, a[13:0]};
        2'b01:   to_global = {`FIX_PAGE_1, a[13:0]};
        `WIN_LO: to_global = {pg, a[13:0]};
        default: to_global = {`FIX_PAGE_3, a[13:0]};
      endcase
    end
  endfunction

  // Alternating priority when both request in one cycle
  always @* begin
    case (state)
      ST_IDLE, ST_CPU, ST_DBG: begin
        if (cpu_req_i & dbg_req_i) begin
          next_state = last_dbg ? ST_CPU : ST_DBG;
        end else if (dbg_req_i) begin
          next_state = ST_DBG;
        end else if (cpu_req_i) begin
          next_state = ST_CPU;
        end else begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  assign cpu_gnt_o = (next_state == ST_CPU);
  assign dbg_gnt_o = (next_state == ST_DBG);

  wire [15:0] cpu_local;
  wire        cpu_unmapped;
  wire        dbg_flash;
  wire        dbg_hidden;
  assign cpu_local    = cpu_direct_i ? {direct, cpu_addr_i[7:0]} : cpu_addr_i;
  assign cpu_unmapped = (cpu_local > MAP_TOP) & (cpu_local[15:14] == `WIN_LO);
  assign dbg_flash    = dbg_addr_i[15];
  // Debug resources in the top page only while debug is active
  assign dbg_hidden   = ~dbg_active_i & (dbg_addr_i[15:8] == `DBG_RES_HI);

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state           <= ST_IDLE;
      last_dbg        <= 1'b0;
      glb_addr_o      <= 18'h0;
      glb_valid_o     <= 1'b0;
      misaligned_o    <= 1'b0;
      flash_blk_o     <= 1'b0;
      sys_reset_req_o <= 1'b0;
    end else begin
      state           <= next_state;
      glb_valid_o     <= 1'b0;
      flash_blk_o     <= 1'b0;
      sys_reset_req_o <= 1'b0;
      if (next_state == ST_CPU) begin
        last_dbg        <= 1'b0;
        glb_addr_o      <= to_global(cpu_local, page);
        misaligned_o    <= cpu_local[0];
        glb_valid_o     <= ~cpu_unmapped;
        sys_reset_req_o <= cpu_unmapped;
      end else if (next_state == ST_DBG) begin
        last_dbg     <= 1'b1;
        glb_addr_o   <= to_global(dbg_addr_i, page);
        misaligned_o <= dbg_addr_i[0];
        if (secured_i & dbg_ext_i & dbg_flash) begin
          flash_blk_o <= 1'b1;
        end else begin
          glb_valid_o <= ~dbg_hidden;
        end
      end
    end
  end
endmodule

// File: verification/mmc_checker.sv
// Port checker for the memory map control block.
// Assumes it is bound onto mmc_top and sees only its ports.
`timescale 1ns/1ps
module mmc_checker #(
  parameter MAP_TOP = 16'hbfff
) (
  input wire logic        ref_clk_i,      // Clock
  input wire logic        rst_n_i,        // Reset
  input wire logic        secured_i,      // Secured
  input wire logic        cpu_req_i,      // Core req
  input wire logic [15:0] cpu_addr_i,     // Core addr
  input wire logic        cpu_direct_i,   // Direct mode
  input wire logic        dbg_req_i,      // Debug req
  input wire logic [15:0] dbg_addr_i,     // Debug addr
  input wire logic        dbg_ext_i,      // External
  input wire logic        dbg_active_i,   // Debug active
  input wire logic        cpu_gnt_o,      // Core gnt
  input wire logic        dbg_gnt_o,      // Debug gnt
  input wire logic [17:0] glb_addr_o,     // Global addr
  input wire logic        glb_valid_o,    // Valid
  input wire logic        misaligned_o,   // Odd
  input wire logic        flash_blk_o,    // Blocked
  input wire logic        sys_reset_req_o, // Reset req
  input wire logic        special_mode_o, // Special
  input wire logic        debug_entry_o   // Debug entry
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_one_grant: assert property (!(cpu_gnt_o && dbg_gnt_o)) else $error("two grants");
  a_tie_turn: assert property (cpu_req_i && dbg_req_i && dbg_gnt_o |=>
    (cpu_req_i && dbg_req_i) |-> cpu_gnt_o) else $error("tie not alternated");
  a_grant_done: assert property ((cpu_gnt_o || (dbg_gnt_o && (dbg_active_i || dbg_addr_i[15:8] != 8'hff))) |=>
    glb_valid_o || flash_blk_o || sys_reset_req_o) else $error("grant without result");
  a_fixed_page: assert property (cpu_gnt_o && !cpu_direct_i && cpu_addr_i[15:14] == 2'b01
    |=> glb_addr_o == {4'hd, $past(cpu_addr_i[13:0])}) else $error("fixed page wrong");
  a_odd_flag: assert property (cpu_gnt_o |=> misaligned_o == $past(cpu_addr_i[0]))
    else $error("misaligned flag wrong");
  a_sec_block: assert property (secured_i && dbg_gnt_o && dbg_ext_i && dbg_addr_i[15]
    |=> flash_blk_o) else $error("secured access not blocked");
  a_unmapped: assert property (cpu_gnt_o && !cpu_direct_i && cpu_addr_i[15:14] == 2'b10
    && cpu_addr_i > MAP_TOP |=> sys_reset_req_o) else $error("no reset on unmapped");
  a_debug_entry: assert property (debug_entry_o |-> special_mode_o)
    else $error("debug entry outside special mode");
endmodule
bind mmc_top mmc_checker #(.MAP_TOP(MAP_TOP)) mmc_checker_inst (.*);

// File: verification/mmc_masters.sv
// Core and debug master model: one-cycle requests, grants captured.
// Assumes the bench calls go and reads cg and dg afterwards.
`timescale 1ns/1ps
module mmc_masters (
  input  wire logic        ref_clk_i,  // Clock
  input  wire logic        cpu_gnt_i,  // Core gnt
  input  wire logic        dbg_gnt_i,  // Debug gnt
  output logic             cpu_req_o,  // Core req
  output logic [15:0]      cpu_addr_o, // Core addr
  output logic             cpu_dir_o,  // Direct mode
  output logic             dbg_req_o,  // Debug req
  output logic [15:0]      dbg_addr_o, // Debug addr
  output logic             dbg_ext_o   // External
);
  logic cg, dg;
  initial {cpu_req_o, cpu_addr_o, cpu_dir_o, dbg_req_o, dbg_addr_o, dbg_ext_o} = '0;
  task go(input c, input d, input [15:0] ca, input [15:0] da, input dr, input ex);
    @(posedge ref_clk_i);
    {cpu_req_o, dbg_req_o, cpu_dir_o, dbg_ext_o} <= {c, d, dr, ex};
    {cpu_addr_o, dbg_addr_o} <= {ca, da};
    @(posedge ref_clk_i);
    {cg, dg} = {cpu_gnt_i, dbg_gnt_i};
    // Released lines flip so stale values never pass
    {cpu_req_o, dbg_req_o, cpu_addr_o, dbg_addr_o} <= {2'b00, ~ca, ~da};
  endtask
endmodule

// File: verification/test_memory_map_mode_control.sv
// Bench for the memory map control block over APB and two masters.
// Assumes reset starts with the mode pin low, so special mode.
`timescale 1ns/1ps
module test_memory_map_mode_control;
  logic clk, rst_n, pin, sec, act, psel, penable, pwrite, seen;
  logic [31:0] paddr, pwdata, prdata;
  logic pready, pslverr, cg, dg, valid, mis, blk, sysr, spec, dbe, creq, cdir, dreq, dext;
  logic [15:0] ca, da;
  logic [17:0] ga;
  int bad_count, cmp_count, cyc;
  mmc_top #(.MAP_TOP(16'h9fff)) mmc_top_inst (.ref_clk_i(clk), .rst_n_i(rst_n),
    .mode_select_pin_i(pin), .secured_i(sec), .cpu_req_i(creq), .cpu_addr_i(ca),
    .cpu_direct_i(cdir), .dbg_req_i(dreq), .dbg_addr_i(da), .dbg_ext_i(dext),
    .dbg_active_i(act), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .cpu_gnt_o(cg),
    .dbg_gnt_o(dg), .glb_addr_o(ga), .glb_valid_o(valid), .misaligned_o(mis),
    .flash_blk_o(blk), .sys_reset_req_o(sysr), .special_mode_o(spec), .debug_entry_o(dbe));
  mmc_masters mmc_masters_inst (.ref_clk_i(clk), .cpu_gnt_i(cg), .dbg_gnt_i(dg),
    .cpu_req_o(creq), .cpu_addr_o(ca), .cpu_dir_o(cdir), .dbg_req_o(dreq),
    .dbg_addr_o(da), .dbg_ext_o(dext));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (dbe === 1'b1) seen <= 1'b1;
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict;
    end
  end
  task chk(input [31:0] g, input [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task apb(input w, input [7:0] i, input [7:0] d, output [31:0] r);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, 22'h0, i, 2'b00, 24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task wr(input [7:0] i, input [7:0] d);
    logic [31:0] r;
    apb(1'b1, i, d, r);
  endtask
  task rd(input [7:0] i, input [7:0] e);
    logic [31:0] r;
    apb(1'b0, i, 8'h00, r);
    chk(r, {24'h0, e});
  endtask
  task t_mode;
    chk(spec, 1'b1);
    chk(seen, 1'b1);
    rd(8'h0b, 8'h00);
    sec <= 1'b1;
    wr(8'h0b, 8'h80);
    rd(8'h0b, 8'h00);
    sec <= 1'b0;
    wr(8'h0b, 8'h80);
    rd(8'h0b, 8'h80);
    wr(8'h0b, 8'h00);
    rd(8'h0b, 8'h80);
  endtask
  task t_regs;
    logic [7:0] rs [0:5];
    rs = '{8'h0a, 8'h10, 8'h12, 8'h13, 8'h14, 8'h20};
    rd(8'h15, 8'h0e);
    foreach (rs[k]) begin
      wr(rs[k], 8'hff);
      rd(rs[k], 8'h00);
    end
    wr(8'h11, 8'h80);
    wr(8'h11, 8'h40);
    rd(8'h11, 8'h80);
    wr(8'h15, 8'h05);
  endtask
  task t_page;
    mmc_masters_inst.go(1, 0, 16'h8001, 0, 0, 0);
    #1 chk(ga, {4'h5, 14'h0001});
    chk(mis, 1'b1);
    mmc_masters_inst.go(1, 0, 16'h4002, 0, 0, 0);
    #1 chk(ga, {4'hd, 14'h0002});
    chk(mis, 1'b0);
    mmc_masters_inst.go(1, 0, 16'h0012, 0, 1, 0);
    #1 chk(ga, {4'h5, 14'h0012});
    mmc_masters_inst.go(1, 0, 16'ha000, 0, 0, 0);
    #1 chk(sysr, 1'b1);
    sec <= 1'b1;
    mmc_masters_inst.go(0, 1, 0, 16'h9000, 0, 1);
    #1 chk(blk, 1'b1);
    sec <= 1'b0;
  endtask
  task t_arb;
    // Last grant in t_page went to debug, so the core wins this tie
    mmc_masters_inst.go(1, 1, 16'h4000, 16'hc000, 0, 0);
    chk(mmc_masters_inst.cg, 1'b1);
    #1 chk(ga, {4'hd, 14'h0});
    mmc_masters_inst.go(1, 1, 16'h4000, 16'hc000, 0, 0);
    chk(mmc_masters_inst.dg, 1'b1);
    #1 chk(ga, {4'hf, 14'h0});
  endtask
  task t_strap;
    @(posedge clk);
    pin <= 1'b1;
    seen <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk(spec, 1'b0);
    chk(seen, 1'b0);
    rd(8'h0b, 8'h80);
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {clk, rst_n, pin, sec, act, psel, penable, pwrite, seen} = '0;
    {paddr, pwdata} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // Strap capture needs three edges after release
    repeat (5) @(posedge clk);
    t_mode;
    t_regs;
    t_page;
    t_arb;
    t_strap;
    give_verdict;
  end
endmodule
